/* File: hw/scr_sysctl.sv */
// System control register bank on a classic Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Primary low boots flash; high/secondary-low boots ROM.
// - Boot pins latched on fourth edge after reset.
// - Offset zero shows latched boot pins read-only.
// - Seven sticky reset-cause flags, bits 31..25.
// - Writing bit 24 clears all cause flags.
// - Bit 1 gates the external-logic reset.
// - Writing bit 0 triggers software reset.
// - Low-power field selects sleep, stop, standby.
// - Flash clock divides system clock by field+1.
// - Bit 5 powers PLL; bit 6 shows ready.
// - Crystal on, bypass, and ready status bits.
// - Five bits release debug pins for general use.
// - Debug halts calendar and free watchdog if set.
// - Rise/fall selects enable wake sources per edge.
// - Selected wake event sets its pending bit.
// - Peripheral bus clock divides by field+1.
// - Slow-bus unit resets held while bit set.
// - Four fast-bus unit resets held while set.
// - Clock gates use reset bit positions.
// - Set bits halt slow-bus clocks in debug.
// - Offset 0x100 returns fixed identifier, writes ignored.
module scr_sysctl #(
   parameter logic [31:0] CHIP_IDENTIFIER = scr_pkg::ID_DEFAULT // Value is arbitrary.
) (
   input wire logic core_clk,
   input wire logic reset_pin,
   input wire logic por_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic startup_pin_primary,
   input wire logic startup_pin_secondary,
   input wire logic [6:0] reset_cause_in,
   input wire logic external_logic_reset_req,
   output logic device_reset_req,
   output logic boot_from_rom,
   output logic [1:0] low_power_select_field,
   output logic flash_clk_tick,
   output logic peripheral_bus_tick,
   output logic pll_power,
   input wire logic pll_ready,
   output logic crystal_power,
   output logic crystal_bypass,
   input wire logic crystal_clock_ready,
   output logic [4:0] debug_pin_user,
   input wire logic debug_active,
   output logic halt_calendar,
   output logic halt_free_watchdog,
   input wire logic [7:0] external_interrupt_lines,
   input wire logic calendar_alarm,
   output logic [8:0] wake_pending,
   output logic [28:0] slow_unit_reset,
   output logic [3:0] fast_unit_reset,
   output logic [28:0] slow_unit_clk_en,
   output logic [3:0] fast_unit_clk_en
);
   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   // Each access answers one cycle after the request; ack drops next cycle.
   logic ack_r;
   logic err_r;
   logic [31:0] rdat_r;
   wire req = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
   wire [8:0] off = wb_adr_i[8:0];
   wire hi_zero = (wb_adr_i[31:9] == '0);
   wire wr = req & wb_we_i;
   // Byte-lane write mask built from sel.
   wire [31:0] bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire hit_rst = hi_zero && off == scr_pkg::OFF_RST;
   wire hit_lp = hi_zero && off == scr_pkg::OFF_LPWR;
   wire hit_clk = hi_zero && off == scr_pkg::OFF_CLK;
   wire hit_dp = hi_zero && off == scr_pkg::OFF_DPIN;
   wire hit_dbg = hi_zero && off == scr_pkg::OFF_DBG;
   wire hit_wr = hi_zero && off == scr_pkg::OFF_WRISE;
   wire hit_wf = hi_zero && off == scr_pkg::OFF_WFALL;
   wire hit_wp = hi_zero && off == scr_pkg::OFF_WPEND;
   wire hit_pd = hi_zero && off == scr_pkg::OFF_PDIV;
   wire hit_sr = hi_zero && off == scr_pkg::OFF_SRST;
   wire hit_fr = hi_zero && off == scr_pkg::OFF_FRST;
   wire hit_sc = hi_zero && off == scr_pkg::OFF_SCLK;
   wire hit_fc = hi_zero && off == scr_pkg::OFF_FCLK;
   wire hit_sh = hi_zero && off == scr_pkg::OFF_SHALT;
   wire hit_bt = hi_zero && off == scr_pkg::OFF_BOOT;
   wire hit_id = hi_zero && off == scr_pkg::OFF_ID;
   wire mapped = hit_rst | hit_lp | hit_clk | hit_dp | hit_dbg | hit_wr
      | hit_wf | hit_wp | hit_pd | hit_sr | hit_fr | hit_sc | hit_fc
      | hit_sh | hit_bt | hit_id;
   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   logic [1:0] boot_r; // Latched boot pins.
   logic [2:0] boot_cnt_r; // Edges since reset release.
   logic [1:0] bp1_r; // Pin synchroniser first stage.
   logic [1:0] bp2_r; // Pin synchroniser second stage.
   logic [6:0] flags_r; // Reset-cause flags.
   logic ext_gate_r;
   logic sw_rst_r; // One-cycle software reset pulse.
   logic [1:0] lp_r;
   logic [7:0] fdiv_r; // High and low flash divider nibbles.
   logic pll_on_r;
   logic xtal_on_r;
   logic xtal_byp_r;
   logic [4:0] dpin_r;
   logic [1:0] dbg_r; // Calendar and free watchdog halt selects.
   logic [8:0] wrise_r;
   logic [8:0] wfall_r;
   logic [3:0] pdiv_r;
   logic [28:0] srst_r;
   logic [3:0] frst_r;
   logic [28:0] sclk_r;
   logic [3:0] fclk_r;
   logic [28:0] shalt_r;
   logic [1:0] stat_s1_r; // Ready status synchroniser first stage.
   logic [1:0] stat_s2_r; // Ready status synchroniser second stage.
   // Write data under the byte mask, one word shared by every register except ext_gate_r.
   wire [31:0] wdm = wb_dat_i & bm;
   // Clear-all and software reset act on a written one in their lane.
   wire clr_all = wr & hit_rst & wdm[scr_pkg::CLEAR_ALL_BIT];
   wire sw_go = wr & hit_rst & wdm[scr_pkg::SW_RST_BIT];
   wire [8:0] wake_clr = (wr & hit_wp) ? wdm[8:0] : 9'h000;
   // External logic reset only counts when its gate is open.
   wire ext_taken = ext_gate_r & external_logic_reset_req;
   wire [6:0] cause_now = {reset_cause_in[6:1], reset_cause_in[0] | ext_taken};
   // ------------------------------------------------------------------
   // Reset-cause flags
   // ------------------------------------------------------------------
   // Held only by the power-on reset, so the core reset does not wipe the
   // history that software wants to read after restarting. A cause that
   // arrives with a clear wins over it.
   always_ff @(posedge core_clk or negedge por_n)
   begin
      if (!por_n)
      begin
         flags_r <= scr_pkg::FLAG_INIT;
      end
      else
      begin
         flags_r <= cause_now | (clr_all ? 7'h00 : flags_r);
      end
   end
   // ------------------------------------------------------------------
   // Boot pin capture
   // ------------------------------------------------------------------
   // Pins are synchronised, then frozen on the fourth edge after release.
   always_ff @(posedge core_clk or negedge reset_pin)
   begin
      if (!reset_pin)
      begin
         bp1_r <= 2'h0;
         bp2_r <= 2'h0;
         boot_cnt_r <= 3'h0;
         boot_r <= 2'h0;
      end
      else
      begin
         bp1_r <= {startup_pin_secondary, startup_pin_primary};
         bp2_r <= bp1_r;
         if (boot_cnt_r != scr_pkg::BOOT_LATCH_EDGE)
         begin
            boot_cnt_r <= boot_cnt_r + 3'h1;
         end
         if (boot_cnt_r == scr_pkg::BOOT_LATCH_EDGE - 3'h1)
         begin
            boot_r <= bp2_r;
         end
      end
   end
   // ROM only when primary high and secondary low; else main flash.
   assign boot_from_rom = boot_r[0] & ~boot_r[1];
   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_pin)
   begin
      if (!reset_pin)
      begin
         ext_gate_r <= 1'b0;
         sw_rst_r <= 1'b0;
         lp_r <= 2'h0;
         fdiv_r <= 8'h00;
         pll_on_r <= 1'b0;
         xtal_on_r <= 1'b0;
         xtal_byp_r <= 1'b0;
         dpin_r <= 5'h00;
         dbg_r <= 2'h0;
         wrise_r <= 9'h000;
         wfall_r <= 9'h000;
         pdiv_r <= 4'h0;
         srst_r <= scr_pkg::SLOW_RST_INIT[28:0];
         frst_r <= scr_pkg::SLOW_RST_INIT[3:0];
         sclk_r <= scr_pkg::CLK_GATE_INIT[28:0];
         fclk_r <= scr_pkg::CLK_GATE_INIT[3:0];
         shalt_r <= 29'h0;
         stat_s1_r <= 2'h0;
         stat_s2_r <= 2'h0;
      end
      else
      begin
         stat_s1_r <= {pll_ready, crystal_clock_ready};
         stat_s2_r <= stat_s1_r;
         sw_rst_r <= sw_go;
         if (wr & hit_rst & wb_sel_i[0])
         begin
            ext_gate_r <= wb_dat_i[scr_pkg::EXT_GATE_BIT];
         end
         // Byte lanes without sel keep their old bits.
         if (wr & hit_lp)
         begin
            lp_r <= (lp_r & ~bm[1:0]) | wdm[1:0];
         end
         if (wr & hit_clk)
         begin
            fdiv_r <= (fdiv_r & ~bm[15:8]) | wdm[15:8];
            pll_on_r <= (pll_on_r & ~bm[5]) | wdm[5];
            xtal_on_r <= (xtal_on_r & ~bm[2]) | wdm[2];
            xtal_byp_r <= (xtal_byp_r & ~bm[3]) | wdm[3];
         end
         if (wr & hit_dp)
         begin
            dpin_r <= (dpin_r & ~bm[4:0]) | wdm[4:0];
         end
         if (wr & hit_dbg)
         begin
            dbg_r <= (dbg_r & ~bm[4:3]) | wdm[4:3];
         end
         if (wr & hit_wr)
         begin
            wrise_r <= (wrise_r & ~bm[8:0]) | wdm[8:0];
         end
         if (wr & hit_wf)
         begin
            wfall_r <= (wfall_r & ~bm[8:0]) | wdm[8:0];
         end
         if (wr & hit_pd)
         begin
            pdiv_r <= (pdiv_r & ~bm[3:0]) | wdm[3:0];
         end
         if (wr & hit_sr)
         begin
            srst_r <= (srst_r & ~bm[28:0]) | wdm[28:0];
         end
         if (wr & hit_fr)
         begin
            frst_r <= (frst_r & ~bm[3:0]) | wdm[3:0];
         end
         if (wr & hit_sc)
         begin
            sclk_r <= (sclk_r & ~bm[28:0]) | wdm[28:0];
         end
         if (wr & hit_fc)
         begin
            fclk_r <= (fclk_r & ~bm[3:0]) | wdm[3:0];
         end
         if (wr & hit_sh)
         begin
            shalt_r <= (shalt_r & ~bm[28:0]) | wdm[28:0];
         end
      end
   end
   // ------------------------------------------------------------------
   // Wake logic and dividers
   // ------------------------------------------------------------------
   scr_wake #(.N(scr_pkg::WAKE_SRC)) u_wake (
      .core_clk(core_clk),
      .reset_pin(reset_pin),
      .src({calendar_alarm, external_interrupt_lines}),
      .rise_sel(wrise_r),
      .fall_sel(wfall_r),
      .clr(wake_clr),
      .pend(wake_pending)
   );
   // The low nibble is expected to mirror the high one; only high is used.
   scr_clk_div #(.W(4)) u_fdiv (
      .core_clk(core_clk),
      .reset_pin(reset_pin),
      .ratio(fdiv_r[7:4]),
      .tick(flash_clk_tick)
   );
   scr_clk_div #(.W(4)) u_pdiv (
      .core_clk(core_clk),
      .reset_pin(reset_pin),
      .ratio(pdiv_r),
      .tick(peripheral_bus_tick)
   );
   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign device_reset_req = sw_rst_r | ext_taken;
   assign low_power_select_field = lp_r;
   assign pll_power = pll_on_r;
   assign crystal_power = xtal_on_r;
   assign crystal_bypass = xtal_byp_r;
   assign debug_pin_user = dpin_r;
   assign halt_calendar = debug_active & dbg_r[1];
   assign halt_free_watchdog = debug_active & dbg_r[0];
   assign slow_unit_reset = srst_r;
   assign fast_unit_reset = frst_r;
   // Gate off in debug when the halt bit for that unit is set.
   assign slow_unit_clk_en = sclk_r & ~(shalt_r & {29{debug_active}});
   assign fast_unit_clk_en = fclk_r;
   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   wire [31:0] rd_mux =
      hit_bt ? {30'h0, boot_r} :
      hit_rst ? {flags_r, 23'h0, ext_gate_r, 1'b0} :
      hit_lp ? {30'h0, lp_r} :
      hit_clk ? {16'h0, fdiv_r, 1'b0, stat_s2_r[1], pll_on_r,
                 stat_s2_r[0], xtal_byp_r, xtal_on_r, 2'h0} :
      hit_dp ? {27'h0, dpin_r} :
      hit_dbg ? {27'h0, dbg_r, 3'h0} :
      hit_wr ? {23'h0, wrise_r} :
      hit_wf ? {23'h0, wfall_r} :
      hit_wp ? {23'h0, wake_pending} :
      hit_pd ? {28'h0, pdiv_r} :
      hit_sr ? {3'h0, srst_r} :
      hit_fr ? {28'h0, frst_r} :
      hit_sc ? {3'h0, sclk_r} :
      hit_fc ? {28'h0, fclk_r} :
      hit_sh ? {3'h0, shalt_r} :
      hit_id ? CHIP_IDENTIFIER : 32'h0;
   // ------------------------------------------------------------------
   // Bus answer
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_pin)
   begin
      if (!reset_pin)
      begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
         rdat_r <= 32'h0;
      end
      else
      begin
         ack_r <= req & mapped;
         err_r <= req & ~mapped;
         rdat_r <= (req & ~wb_we_i) ? rd_mux : rdat_r;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;
   assign wb_dat_o = rdat_r;
   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_boot_frozen: assert property (@(posedge core_clk) disable iff (!reset_pin)
      boot_cnt_r == scr_pkg::BOOT_LATCH_EDGE ##1 1'b1 |-> $stable(boot_r))
      else $error("boot latch moved after capture");
   a_boot_rom: assert property (@(posedge core_clk) disable iff (!reset_pin)
      boot_from_rom |-> boot_r == 2'h1)
      else $error("rom boot with wrong pins");
   a_flags_clear: assert property (@(posedge core_clk) disable iff (!por_n)
      clr_all && cause_now == 7'h0 |=> flags_r == 7'h0)
      else $error("clear-all did not clear flags");
   a_flags_keep: assert property (@(posedge core_clk) disable iff (!por_n)
      !clr_all |=> (flags_r & $past(flags_r)) == $past(flags_r))
      else $error("cause flag lost");
   a_sw_reset: assert property (@(posedge core_clk) disable iff (!reset_pin)
      sw_go |=> device_reset_req)
      else $error("software reset not raised");
   a_ext_gate: assert property (@(posedge core_clk) disable iff (!reset_pin)
      !ext_gate_r && !sw_rst_r |-> !device_reset_req)
      else $error("ungated external reset");
   a_debug_halt: assert property (@(posedge core_clk) disable iff (!reset_pin)
      !debug_active |-> slow_unit_clk_en == sclk_r && !halt_calendar)
      else $error("halt outside debug");
   a_id_read: assert property (@(posedge core_clk) disable iff (!reset_pin)
      req && !wb_we_i && hit_id |=> wb_ack_o && wb_dat_o == CHIP_IDENTIFIER)
      else $error("wrong identifier");
   a_ack_once: assert property (@(posedge core_clk) disable iff (!reset_pin)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
endmodule
`default_nettype wire

/* File: hw/scr_pkg.sv */
// Package with register map, field positions and timing for the system control bank.
package scr_pkg;
   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [8:0] OFF_BOOT = 9'h000;
   localparam logic [8:0] OFF_RST = 9'h004;
   localparam logic [8:0] OFF_LPWR = 9'h008;
   localparam logic [8:0] OFF_CLK = 9'h00c;
   localparam logic [8:0] OFF_DPIN = 9'h014;
   localparam logic [8:0] OFF_DBG = 9'h01c;
   localparam logic [8:0] OFF_WRISE = 9'h020;
   localparam logic [8:0] OFF_WFALL = 9'h024;
   localparam logic [8:0] OFF_WPEND = 9'h028;
   localparam logic [8:0] OFF_PDIV = 9'h038;
   localparam logic [8:0] OFF_SRST = 9'h040;
   localparam logic [8:0] OFF_FRST = 9'h050;
   localparam logic [8:0] OFF_SCLK = 9'h060;
   localparam logic [8:0] OFF_FCLK = 9'h070;
   localparam logic [8:0] OFF_SHALT = 9'h080;
   localparam logic [8:0] OFF_ID = 9'h100;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int FLAG_LSB = 25;
   localparam int CLEAR_ALL_BIT = 24;
   localparam int EXT_GATE_BIT = 1;
   localparam int SW_RST_BIT = 0;
   localparam int FDIV_HI_LSB = 12;
   localparam int FDIV_LO_LSB = 8;
   localparam int PLL_RDY_BIT = 6;
   localparam int PLL_ON_BIT = 5;
   localparam int XTAL_RDY_BIT = 4;
   localparam int XTAL_BYP_BIT = 3;
   localparam int XTAL_ON_BIT = 2;
   localparam int HALT_CAL_BIT = 4;
   localparam int HALT_FWD_BIT = 3;
   // ------------------------------------------------------------------
   // Widths, reset values and timing
   // ------------------------------------------------------------------
   localparam int SLOW_UNITS = 29;
   localparam int FAST_UNITS = 4;
   localparam int WAKE_SRC = 9;
   localparam int CAUSES = 7;
   localparam logic [31:0] SLOW_RST_INIT = 32'h0000_0000;
   localparam logic [31:0] CLK_GATE_INIT = 32'h0000_0000;
   localparam logic [2:0] BOOT_LATCH_EDGE = 3'h4;
   localparam logic [31:0] ID_DEFAULT = 32'h5ca1_0001; // Value is arbitrary.
   localparam logic [6:0] FLAG_INIT = 7'h04; // Power-on flag set.
   // Reset cause index within the flag field (bit 25 + index).
   localparam int C_EXT = 0;
   localparam int C_PIN = 1;
   localparam int C_POR = 2;
   localparam int C_SFT = 3;
   localparam int C_FWD = 4;
   localparam int C_WDG = 5;
   localparam int C_LPW = 6;
endpackage

/* File: hw/scr_clk_div.sv */
// Programmable clock-enable divider, ratio field plus one.
`timescale 1ns/1ps
`default_nettype none
module scr_clk_div #(
   parameter int W = 4
) (
   input wire logic core_clk,
   input wire logic reset_pin,
   input wire logic [W-1:0] ratio,
   output logic tick
);
   // Cycle counter inside one divided period.
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   wire wrap = (cnt_r >= ratio);
   assign cnt_nxt = wrap ? '0 : cnt_r + 1'b1;
   // Tick marks one system cycle per divided period; ratio 0 gives every cycle.
   assign tick = wrap;
   // ------------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_pin)
   begin
      if (!reset_pin)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: hw/scr_wake.sv */
// Wake edge detector and sticky pending flags, write one to clear.
`timescale 1ns/1ps
`default_nettype none
module scr_wake #(
   parameter int N = 9
) (
   input wire logic core_clk,
   input wire logic reset_pin,
   input wire logic [N-1:0] src,
   input wire logic [N-1:0] rise_sel,
   input wire logic [N-1:0] fall_sel,
   input wire logic [N-1:0] clr,
   output logic [N-1:0] pend
);
   // Two-stage synchroniser, then a third stage that edge detection reads.
   logic [N-1:0] s1_r;
   logic [N-1:0] s2_r;
   logic [N-1:0] s3_r;
   logic [N-1:0] pend_r;
   logic [N-1:0] evt;
   logic [N-1:0] pend_nxt;
   assign evt = (rise_sel & s2_r & ~s3_r) | (fall_sel & ~s2_r & s3_r);
   // A new event wins over a clear arriving in the same cycle.
   assign pend_nxt = evt | (pend_r & ~clr);
   assign pend = pend_r;
   // ------------------------------------------------------------------
   // Sync and flags
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_pin)
   begin
      if (!reset_pin)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         pend_r <= '0;
      end
      else
      begin
         s1_r <= src;
         s2_r <= s1_r;
         s3_r <= s2_r;
         pend_r <= pend_nxt;
      end
   end
   a_pend_sticky: assert property (@(posedge core_clk) disable iff (!reset_pin)
      $past(pend_r) != 0 && $past(clr) == 0 |-> (pend_r & $past(pend_r)) == $past(pend_r))
      else $error("pending flag dropped without clear");
endmodule
`default_nettype wire

/* File: testbench/scr_sysctl_tb_top.sv */
// Self-checking testbench for the system control register bank.
`timescale 1ns/1ps
`default_nettype none
module scr_sysctl_tb_top;
   // ------------------------------------------------------------
   // Stimulus, observed outputs and scoreboard state
   // ------------------------------------------------------------
   logic core_clk = 1'h0, reset_pin = 1'h0, por_n = 1'h0;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, v;
   logic [3:0] wb_sel_i = 4'hf; // Whole words only.
   logic wb_ack_o, wb_err_o, device_reset_req, boot_from_rom;
   logic startup_pin_primary = 1'h1, startup_pin_secondary = 1'h1;
   logic [6:0] reset_cause_in = 7'h0;
   logic external_logic_reset_req = 1'h0, pll_ready = 1'h0;
   logic crystal_clock_ready = 1'h0, debug_active = 1'h0;
   logic [7:0] external_interrupt_lines = 8'h0;
   logic calendar_alarm = 1'h0, flash_clk_tick, peripheral_bus_tick;
   logic pll_power, crystal_power, crystal_bypass;
   logic halt_calendar, halt_free_watchdog;
   logic [1:0] low_power_select_field;
   logic [4:0] debug_pin_user;
   logic [8:0] wake_pending;
   logic [28:0] slow_unit_reset, slow_unit_clk_en;
   logic [3:0] fast_unit_reset, fast_unit_clk_en;
   int n_rst = 0, n_err = 0; // Reset request cycles and bus errors seen.
   logic [63:0] q[$]; // Read notes: mask in the upper half.
   logic [63:0] e;
   logic [31:0] offs[11] = '{32'h8, 32'h14, 32'h1c, 32'h20, 32'h24,
      32'h38, 32'h40, 32'h50, 32'h60, 32'h70, 32'h80};
   logic [31:0] msk[11] = '{32'h3, 32'h1f, 32'h18, 32'h1ff, 32'h1ff,
      32'hf, 32'h1fff_ffff, 32'hf, 32'h1fff_ffff, 32'hf, 32'h1fff_ffff};
   int n_fail = 0, compares = 0;
   scr_sysctl DUT (.core_clk, .reset_pin, .por_n, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
      .wb_err_o, .startup_pin_primary, .startup_pin_secondary,
      .reset_cause_in, .external_logic_reset_req, .device_reset_req,
      .boot_from_rom, .low_power_select_field, .flash_clk_tick,
      .peripheral_bus_tick, .pll_power, .pll_ready, .crystal_power,
      .crystal_bypass, .crystal_clock_ready, .debug_pin_user,
      .debug_active, .halt_calendar, .halt_free_watchdog,
      .external_interrupt_lines, .calendar_alarm, .wake_pending,
      .slow_unit_reset, .fast_unit_reset, .slow_unit_clk_en,
      .fast_unit_clk_en);
   always #4 core_clk = ~core_clk;
   // ------------------------------------------------------------
   // Tasks: compare, bus cycle, tick spacing, reset with boot pins
   // ------------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'h1)
      begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   // Holds the request until ack or err is sampled high.
   task automatic wb(input logic w, input logic [31:0] a, d, m);
      @(posedge core_clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      if (!w)
         q.push_back({m, d & m});
      do @(posedge core_clk);
      while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask
   task automatic per(input logic f, input int n);
      int c;
      c = 0;
      do @(posedge core_clk);
      while ((f ? flash_clk_tick : peripheral_bus_tick) !== 1'h1 && ++c < 40);
      c = 0;
      do
      begin
         @(posedge core_clk);
         c++;
      end
      while ((f ? flash_clk_tick : peripheral_bus_tick) !== 1'h1 && c < 40);
      chk(c == n, "tick spacing");
   endtask
   // Pins flip after the latch edge, so a late sample would show.
   task automatic boot(input logic a, b);
      startup_pin_primary <= a;
      startup_pin_secondary <= b;
      reset_pin <= 1'h0;
      repeat (2) @(posedge core_clk);
      reset_pin <= 1'h1;
      por_n <= 1'h1;
      repeat (6) @(posedge core_clk);
      startup_pin_primary <= ~a;
      startup_pin_secondary <= ~b;
      #1;
   endtask
   task automatic summarize();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Scoreboard: every read answer takes the oldest note.
   always @(posedge core_clk)
   begin
      if (device_reset_req === 1'h1)
         n_rst <= n_rst + 1;
      if (wb_err_o === 1'h1)
         n_err <= n_err + 1;
      if ((wb_ack_o === 1'h1 || wb_err_o === 1'h1) && !wb_we_i)
      begin
         e = q.pop_front();
         chk((wb_dat_o & e[63:32]) === e[31:0], "read data");
      end
   end
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(99716));
      boot(1'h1, 1'h1);
      wb(0, 32'h0, 32'h3, 32'hffff_ffff);
      wb(0, 32'h4, 32'h0800_0000, 32'hfe00_0000);
      reset_cause_in <= 7'h20;
      wb(0, 32'h4, 32'h4800_0000, 32'hfe00_0000);
      reset_cause_in <= 7'h0;
      wb(1, 32'h4, 32'h0100_0000, 32'h0);
      wb(0, 32'h4, 32'h0, 32'hfe00_0000);
      v = n_rst;
      wb(1, 32'h4, 32'h1, 32'h0);
      repeat (3) @(posedge core_clk);
      chk(n_rst == v + 1, "software reset");
      external_logic_reset_req <= 1'h1;
      v = n_rst;
      repeat (3) @(posedge core_clk);
      chk(n_rst == v, "gated request");
      wb(1, 32'h4, 32'h2, 32'h0);
      repeat (3) @(posedge core_clk);
      chk(n_rst > v, "ungated request");
      external_logic_reset_req <= 1'h0;
      wb(1, 32'h4, 32'h0, 32'h0);
      for (int i = 0; i < 11; i++)
      begin
         v = $urandom();
         wb(1, offs[i], v, 32'h0);
         wb(0, offs[i], v, msk[i]);
      end
      for (int k = 0; k < 4; k++)
         if (k != 2)
         begin
            wb(1, 32'h8, k, 32'h0);
            #1 chk(low_power_select_field === k[1:0], "mode");
         end
      wb(1, 32'h14, 32'h15, 32'h0);
      #1 chk(debug_pin_user === 5'h15, "pin release");
      wb(1, 32'h40, 32'h1000_0001, 32'h0);
      #1 chk(slow_unit_reset === 29'h1000_0001, "slow reset");
      wb(1, 32'h50, 32'h5, 32'h0);
      #1 chk(fast_unit_reset === 4'h5, "fast reset");
      wb(1, 32'h70, 32'ha, 32'h0);
      #1 chk(fast_unit_clk_en === 4'ha, "fast gate");
      debug_active <= 1'h1;
      wb(1, 32'h1c, 32'h18, 32'h0);
      #1 chk({halt_calendar, halt_free_watchdog} === 2'h3, "halt");
      wb(1, 32'h60, 32'hffff_ffff, 32'h0);
      wb(1, 32'h80, 32'h2, 32'h0);
      #1 chk(slow_unit_clk_en === 29'h1fff_fffd, "debug stop");
      debug_active <= 1'h0;
      @(posedge core_clk);
      #1 chk(slow_unit_clk_en === 29'h1fff_ffff, "run");
      wb(1, 32'h38, 32'h0, 32'h0);
      per(1'h0, 1);
      wb(1, 32'h38, 32'hf, 32'h0);
      per(1'h0, 16);
      pll_ready <= 1'h1;
      crystal_clock_ready <= 1'h1;
      wb(1, 32'h0c, 32'h332c, 32'h0);
      per(1'h1, 4);
      wb(0, 32'h0c, 32'h337c, 32'hff7c);
      chk({pll_power, crystal_power, crystal_bypass} === 3'h7, "osc");
      wb(1, 32'h20, 32'h1, 32'h0);
      wb(1, 32'h24, 32'h100, 32'h0);
      calendar_alarm <= 1'h1;
      external_interrupt_lines <= 8'h1;
      repeat (5) @(posedge core_clk);
      wb(0, 32'h28, 32'h1, 32'h1ff);
      wb(1, 32'h28, 32'h0, 32'h0);
      wb(0, 32'h28, 32'h1, 32'h1ff);
      wb(1, 32'h28, 32'h1, 32'h0);
      calendar_alarm <= 1'h0;
      repeat (5) @(posedge core_clk);
      wb(0, 32'h28, 32'h100, 32'h1ff);
      wb(0, 32'h100, scr_pkg::ID_DEFAULT, 32'hffff_ffff);
      wb(1, 32'h100, 32'h0, 32'h0);
      wb(0, 32'h100, scr_pkg::ID_DEFAULT, 32'hffff_ffff);
      wb(0, 32'h10, 32'h0, 32'hffff_ffff);
      reset_cause_in <= 7'h2;
      @(posedge core_clk);
      reset_cause_in <= 7'h0;
      boot(1'h1, 1'h0);
      chk(boot_from_rom === 1'h1, "rom boot");
      wb(0, 32'h4, 32'h0600_0000, 32'hfe00_0000);
      boot(1'h0, 1'h1);
      chk(boot_from_rom === 1'h0, "flash boot");
      chk(n_err == 1, "bus error");
      summarize();
   end
   initial
   begin
      #200000;
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire
